// ===== inc/srbt_regs.vh
// register map, field positions and timing constants of the ram self-test
`ifndef SRBT_REGS_VH
`define SRBT_REGS_VH
`define SRBT_ADDR_CONTROL   12'h000
`define SRBT_ADDR_KEY       12'h004
`define SRBT_ADDR_RESET     12'h008
`define SRBT_ADDR_STATUS    12'h00C
`define SRBT_BIT_ARM        0
`define SRBT_BIT_FAIL       4
`define SRBT_BIT_DONE       7
`define SRBT_BIT_FINJ       8
`define SRBT_CTRL_MASK      16'h0191
`define SRBT_KEY_FIRST      8'h55
`define SRBT_KEY_SECOND     8'hAA
`define SRBT_RESET_CODE     32'h0000_0001
`define SRBT_TEST_CLK_MHZ   125
`define SRBT_CORE_CLK_MHZ   200
`define SRBT_RESET_HOLD     4
`endif

// ===== verilog/srbt_ram.v
// single-port ram under test, registered read data
`timescale 1ns/100ps
module srbt_ram #(
  parameter AW = 12,
  parameter DW = 16
) (
  input  wire          i_core_clk,
  input  wire          i_ce,
  input  wire          i_we,
  input  wire [AW-1:0] i_addr,
  input  wire [DW-1:0] i_wdata,
  input  wire [DW-1:0] i_flip,
  output reg  [DW-1:0] o_rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  // i_flip lets a bench invert chosen data bits of every word written to the array
  always @(posedge i_core_clk) begin
    if (i_ce) begin
      if (i_we)
        mem[i_addr] <= i_wdata ^ i_flip;
      o_rdata <= mem[i_addr];
    end
  end
endmodule

// ===== verilog/srbt_top.v
// ram built-in self-test controller with apb control registers
`timescale 1ns/100ps
`include "srbt_regs.vh"
module srbt_top #(
  parameter AW = 12,
  parameter DW = 16
) (
  input  wire          i_core_clk,
  input  wire          i_rst_n,
  input  wire          i_ce,
  input  wire          i_por,
  input  wire          i_cfg_loaded,
  input  wire          i_startup_test_disable_fuse,
  input  wire          i_pll_locked,
  input  wire [DW-1:0] i_ram_flip,
  input  wire          i_psel,
  input  wire          i_penable,
  input  wire          i_pwrite,
  input  wire [11:0]   i_paddr,
  input  wire [31:0]   i_pwdata,
  output reg  [31:0]   o_prdata,
  output reg           o_pready,
  output reg           o_pslverr,
  output reg           o_cpu_run,
  output reg           o_sw_reset_req,
  output reg           o_test_clk_sel,
  output reg           o_software_reset_flag
);
  localparam ST_IDLE  = 6'b000001;
  localparam ST_CLK   = 6'b000010;
  localparam ST_WR    = 6'b000100;
  localparam ST_RD    = 6'b001000;
  localparam ST_CHK   = 6'b010000;
  localparam ST_DONE  = 6'b100000;
  localparam ST_WAIT  = 6'b000000;
  localparam [AW-1:0] LAST = {AW{1'b1}};

  // two-stage synchronisers for pin-level inputs
  reg [1:0] fuse_s_q;
  reg [1:0] lock_s_q;
  reg [1:0] cfg_s_q;
  reg [1:0] por_s_q;

  reg [5:0]    state_q;
  reg          arm_q;
  reg          done_q;
  reg          fail_q;
  reg          finj_q;
  reg          err_q;
  reg [1:0]    key_q;
  reg          pass_q;
  reg [AW-1:0] addr_q;
  reg          por_seen_q;
  reg          started_q;
  reg [2:0]    hold_q;

  wire fuse_dis = fuse_s_q[1];
  wire locked   = lock_s_q[1];
  wire cfg_ok   = cfg_s_q[1];
  wire por_lvl  = por_s_q[1];

  wire          apb_acc = i_psel & i_penable;
  // writes land only on the completing edge, so each one acts once
  wire          apb_wr  = apb_acc & o_pready & i_pwrite;
  wire          mapped  = (i_paddr == `SRBT_ADDR_CONTROL) |
                          (i_paddr == `SRBT_ADDR_KEY) |
                          (i_paddr == `SRBT_ADDR_RESET) |
                          (i_paddr == `SRBT_ADDR_STATUS);
  wire          wr_ctrl = apb_wr & (i_paddr == `SRBT_ADDR_CONTROL);
  wire          wr_key  = apb_wr & (i_paddr == `SRBT_ADDR_KEY);
  wire          wr_rst  = apb_wr & (i_paddr == `SRBT_ADDR_RESET) &
                          (i_pwdata == `SRBT_RESET_CODE);
  wire          unlocked = (key_q == 2'b10);
  wire [15:0]   ctrl_rd = {7'h00, finj_q, done_q, 2'b00, fail_q,
                           3'b000, arm_q};
  wire [15:0]   new_bits = i_pwdata[15:0] & `SRBT_CTRL_MASK & ~ctrl_rd;
  // exactly one new bit may be set per unlock
  wire          one_bit  = (new_bits != 16'h0000) &
                           ((new_bits & (new_bits - 16'h0001)) == 16'h0000);

  wire          ram_we    = (state_q == ST_WR);
  wire          pass_bit  = pass_q;
  wire [DW-1:0] pattern   = pass_bit ? {(DW/2){2'b10}} : {(DW/2){2'b01}};
  wire [DW-1:0] ram_rdata;

  srbt_ram #(
    .AW (AW),
    .DW (DW)
  ) u_ram (
    .i_core_clk (i_core_clk),
    .i_ce       (i_ce),
    .i_we       (ram_we),
    .i_addr     (addr_q),
    .i_wdata    (pattern),
    .i_flip     (i_ram_flip),
    .o_rdata    (ram_rdata)
  );

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fuse_s_q <= 2'b11;
      lock_s_q <= 2'b00;
      cfg_s_q  <= 2'b00;
      por_s_q  <= 2'b00;
    end else if (i_ce) begin
      fuse_s_q <= {fuse_s_q[0], i_startup_test_disable_fuse};
      lock_s_q <= {lock_s_q[0], i_pll_locked};
      cfg_s_q  <= {cfg_s_q[0], i_cfg_loaded};
      por_s_q  <= {por_s_q[0], i_por};
    end
  end

  // sticky flags: cleared by reset only when it is a true power-on
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      por_seen_q <= 1'b0;
    end else if (i_ce) begin
      // armed only once the synced power-on level has been seen
      por_seen_q <= por_seen_q | por_lvl;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_ce) begin
      if (!por_seen_q && por_lvl) begin
        done_q <= 1'b0;
        fail_q <= 1'b0;
        finj_q <= 1'b0;
        arm_q  <= 1'b0;
      end else if (state_q == ST_DONE) begin
        done_q <= 1'b1;
        fail_q <= err_q | finj_q;
        arm_q  <= 1'b0;
      end else if (wr_ctrl && unlocked && one_bit) begin
        if (new_bits[`SRBT_BIT_ARM])
          arm_q <= 1'b1;
        if (new_bits[`SRBT_BIT_FINJ])
          finj_q <= 1'b1;
      end else if (wr_ctrl && unlocked) begin
        if (!i_pwdata[`SRBT_BIT_ARM])
          arm_q <= 1'b0;
        if (!i_pwdata[`SRBT_BIT_FINJ])
          finj_q <= 1'b0;
      end
    end
  end

  // key is consumed by any other access so the unlock must be immediate
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_q <= 2'b00;
    end else if (i_ce && apb_acc && o_pready) begin
      if (wr_key && i_pwdata[7:0] == `SRBT_KEY_FIRST)
        key_q <= 2'b01;
      else if (wr_key && key_q == 2'b01 &&
               i_pwdata[7:0] == `SRBT_KEY_SECOND)
        key_q <= 2'b10;
      else
        key_q <= 2'b00;
    end
  end

  // test engine: when armed, or at power-on with the disable fuse clear, runs out of reset before the cpu is released
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q        <= ST_IDLE;
      started_q      <= 1'b0;
      addr_q         <= {AW{1'b0}};
      pass_q         <= 1'b0;
      err_q          <= 1'b0;
      o_cpu_run      <= 1'b0;
      o_test_clk_sel <= 1'b0;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          if (cfg_ok && !started_q) begin
            started_q <= 1'b1;
            if (arm_q || (por_lvl && !fuse_dis)) begin
              o_test_clk_sel <= 1'b1;
              err_q          <= 1'b0;
              state_q        <= ST_CLK;
            end else begin
              o_cpu_run <= 1'b1;
            end
          end
        end
        ST_CLK: begin
          if (locked) begin
            addr_q  <= {AW{1'b0}};
            pass_q  <= 1'b0;
            state_q <= ST_WR;
          end
        end
        ST_WR: begin
          state_q <= ST_RD;
        end
        ST_RD: begin
          state_q <= ST_CHK;
        end
        ST_CHK: begin
          if (ram_rdata != pattern)
            err_q <= 1'b1;
          if (addr_q != LAST) begin
            addr_q  <= addr_q + {{(AW-1){1'b0}}, 1'b1};
            state_q <= ST_WR;
          end else if (!pass_q) begin
            addr_q  <= {AW{1'b0}};
            pass_q  <= 1'b1;
            state_q <= ST_WR;
          end else begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          o_test_clk_sel <= 1'b0;
          state_q        <= ST_WAIT;
        end
        default: begin
          state_q <= ST_WAIT;
        end
      endcase
    end
  end

  // ram is left corrupt, so a reset is requested after the test
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sw_reset_req <= 1'b0;
      hold_q         <= 3'd0;
    end else if (i_ce) begin
      if (state_q == ST_DONE || wr_rst) begin
        o_sw_reset_req <= 1'b1;
        hold_q         <= 3'd`SRBT_RESET_HOLD;
      end else if (hold_q != 3'd0) begin
        hold_q <= hold_q - 3'd1;
      end else begin
        o_sw_reset_req <= 1'b0;
      end
    end
  end

  // software reset cause, survives the reset it causes
  always @(posedge i_core_clk) begin
    if (i_ce) begin
      if (!por_seen_q && por_lvl)
        o_software_reset_flag <= 1'b0;
      else if (wr_rst)
        o_software_reset_flag <= 1'b1;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else if (i_ce) begin
      o_pready  <= i_psel & i_penable & ~o_pready;
      o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_pwrite) begin
        if (i_paddr == `SRBT_ADDR_CONTROL)
          o_prdata <= {16'h0000, ctrl_rd};
        else if (i_paddr == `SRBT_ADDR_STATUS)
          o_prdata <= {26'h0, state_q};
      end
    end
  end
endmodule

// ===== tb/srbt_plat.sv
// reset, configuration and test clock platform around the controller
`timescale 1ns/100ps
module srbt_plat (
  input  wire logic       i_core_clk,
  input  wire logic       i_por_req,
  input  wire logic       i_reset_req,
  input  wire logic       i_test_clk_sel,
  input  wire logic [3:0] i_lock_dly,
  output logic            o_rst_n,
  output logic            o_por,
  output logic            o_cfg_loaded,
  output logic            o_pll_locked
);
  int   n = 0;
  int   lk = 0;
  logic req_q = 1'b0;
  initial o_por = 1'b1;
  // reset waits for the end of the request pulse so it is never cut short
  always @(posedge i_core_clk) begin
    req_q <= i_reset_req;
    if (i_por_req || (req_q && !i_reset_req)) begin
      n     <= 0;
      o_por <= i_por_req;
    end else if (n < 15) begin
      n <= n + 1;
    end
    if (n == 14)
      o_por <= 1'b0;
    lk <= i_test_clk_sel ? lk + 1 : 0;
  end
  assign o_rst_n      = (n >= 5);
  assign o_cfg_loaded = (n >= 8);
  // lock delay is an input so one run sees a prompt and a slow pll
  assign o_pll_locked = (lk > i_lock_dly);
endmodule

// ===== tb/srbt_asserts.sv
// port assertions for the ram self-test controller
`timescale 1ns/100ps
`include "srbt_regs.vh"
module srbt_asserts #(
  parameter AW = 12,
  parameter DW = 16
) (
  input wire          i_core_clk,
  input wire          i_rst_n,
  input wire          i_ce,
  input wire          i_por,
  input wire          i_cfg_loaded,
  input wire          i_startup_test_disable_fuse,
  input wire          i_pll_locked,
  input wire [DW-1:0] i_ram_flip,
  input wire          i_psel,
  input wire          i_penable,
  input wire          i_pwrite,
  input wire [11:0]   i_paddr,
  input wire [31:0]   i_pwdata,
  input wire [31:0]   o_prdata,
  input wire          o_pready,
  input wire          o_pslverr,
  input wire          o_cpu_run,
  input wire          o_sw_reset_req,
  input wire          o_test_clk_sel,
  input wire          o_software_reset_flag
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take; i_psel && i_penable && !o_pready; endsequence
  sequence s_pulse5; o_sw_reset_req [*5] ##1 !o_sw_reset_req; endsequence
  property p_ans; s_take |=> o_pready; endproperty
  a_ans: assert property (p_ans) else $error("no ready");
  property p_one; o_pready |=> !o_pready; endproperty
  a_one: assert property (p_one) else $error("long ready");
  property p_err; o_pslverr |-> o_pready && o_prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error");
  property p_zero; (s_take ##0 (!i_pwrite && i_paddr == `SRBT_ADDR_CONTROL))
    |=> (o_prdata & ~32'h0000_0191) == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("stray bits");
  property p_pulse; $rose(o_sw_reset_req) |-> s_pulse5; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width");
  property p_swr; (s_take ##0 (i_pwrite && i_paddr == `SRBT_ADDR_RESET &&
    i_pwdata == 32'h1)) |=> ##[0:2] (o_sw_reset_req && o_software_reset_flag);
  endproperty
  a_swr: assert property (p_swr) else $error("no sw reset");
  property p_end; $fell(o_test_clk_sel) |-> ##[0:2] o_sw_reset_req; endproperty
  a_end: assert property (p_end) else $error("no reset after");
  property p_nocpu; o_test_clk_sel |-> !o_cpu_run; endproperty
  a_nocpu: assert property (p_nocpu) else $error("cpu in test");
  property p_lock; o_test_clk_sel && !i_pll_locked |=> o_test_clk_sel;
  endproperty
  a_lock: assert property (p_lock) else $error("left unlocked");
  property p_flag; $fell(o_software_reset_flag) |->
    ($past(i_por, 2) || $past(i_por, 3) || $past(i_por, 4)); endproperty
  a_flag: assert property (p_flag) else $error("flag lost");
endmodule

// ===== tb/tb.sv
// bench for the ram self-test controller with its reset platform
`timescale 1ns/100ps
`include "srbt_regs.vh"
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin fail_count++; \
$display("mismatch t=%0t got=%h exp=%h", $time, g, x); end end
module tb;
  localparam [11:0] CT = `SRBT_ADDR_CONTROL;
  localparam [11:0] KY = `SRBT_ADDR_KEY;
  logic        clk = 1'b0;
  logic        fuse = 1'b1;
  logic        preq = 1'b0;
  logic [15:0] flip = 16'h0000;
  logic [3:0]  dly = 4'h1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd, rd_q;
  logic        rdy, err, err_q, rst_n, por, cfg, lock, run, rreq, sel, swf;
  logic        saw = 1'b0;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  srbt_plat u_plat (.i_core_clk(clk), .i_por_req(preq), .i_reset_req(rreq),
    .i_test_clk_sel(sel), .i_lock_dly(dly), .o_rst_n(rst_n), .o_por(por),
    .o_cfg_loaded(cfg), .o_pll_locked(lock));
  srbt_top #(.AW(4), .DW(16)) dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_ce(1'b1), .i_por(por), .i_cfg_loaded(cfg),
    .i_startup_test_disable_fuse(fuse), .i_pll_locked(lock),
    .i_ram_flip(flip), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(err), .o_cpu_run(run), .o_sw_reset_req(rreq),
    .o_test_clk_sel(sel), .o_software_reset_flag(swf));
  always @(posedge clk) if (sel === 1'b1) saw <= 1'b1;
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    rd_q = prd; err_q = err;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task rd(input [11:0] a, input [31:0] x);
    apb(a, 1'b0, 32'h0);
    `CHK(rd_q, x)
  endtask
  task unl;
    apb(KY, 1'b1, 32'h55);
    apb(KY, 1'b1, 32'hAA);
  endtask
  task boot(input e);
    saw = 1'b0;
    while (run !== 1'b0) @(posedge clk);
    while (run !== 1'b1) @(posedge clk);
    `CHK(saw, e)
  endtask
  task por_up(input f);
    fuse <= f; preq <= 1'b1;
    @(posedge clk);
    preq <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    boot(1'b0);
    rd(CT, 32'h0);
    $display("test skip done");
    por_up(1'b0);
    boot(1'b1);
    rd(CT, 32'h80);
    $display("test startup done");
    apb(CT, 1'b1, 32'h1);
    rd(CT, 32'h80);
    unl; rd(`SRBT_ADDR_STATUS, 32'h1); apb(CT, 1'b1, 32'h1);
    rd(CT, 32'h80);
    unl; apb(CT, 1'b1, 32'h101);
    rd(CT, 32'h80);
    unl; apb(CT, 1'b1, 32'hFE6E);
    rd(CT, 32'h80);
    unl; apb(CT, 1'b1, 32'h1);
    rd(CT, 32'h81);
    apb(12'h010, 1'b0, 32'h0);
    `CHK({err_q, rd_q}, 33'h1_0000_0000)
    $display("test lock done");
    unl; apb(CT, 1'b1, 32'h101);
    rd(CT, 32'h181);
    apb(`SRBT_ADDR_RESET, 1'b1, 32'h1);
    boot(1'b1);
    rd(CT, 32'h190);
    `CHK(swf, 1'b1)
    $display("test inject done");
    flip <= 16'h0100; dly <= 4'hC;
    por_up(1'b0);
    boot(1'b1);
    rd(CT, 32'h90);
    `CHK(swf, 1'b0)
    flip <= 16'h0000;
    por_up(1'b1);
    boot(1'b0);
    rd(CT, 32'h0);
    $display("test ram fault done");
    wrap_up;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up;
    end
  end
endmodule
bind srbt_top srbt_asserts #(.AW(AW), .DW(DW)) u_chk (.*);
